// ### src/virtual_phy_autoneg_advertise.sv
// advertisement and emulated partner ability registers of the emulated phy
`timescale 1ns/1ps
module virtual_phy_autoneg_advertise
    import vphy_adv_pkg::*;
(
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    // configuration strap pin
    input  wire logic                      pause_advert_strap,
    // internal register map access
    input  wire vphy_adv_pkg::reg_req_t    reg_req,
    output logic [31:0]                    reg_rdata,
    output logic                           reg_rvalid,
    // serial management access
    input  wire vphy_adv_pkg::mii_req_t    mii_req,
    output logic [15:0]                    mii_rdata,
    output logic                           mii_rvalid,
    // configuration loader
    input  wire logic                      loader_wr,
    input  wire logic [15:0]               loader_data,
    input  wire logic                      reload_cmd,
    output logic                           loader_busy,
    // registered advertisement to the negotiation logic, one cycle behind the register
    output logic [15:0]                    adv_word
);
    import vphy_adv_pkg::*;

    // ************************************************************
    // strap capture
    // ************************************************************
    logic strap_sync_level;
    logic strap_taken_ff;
    logic nxt_strap_taken;
    logic strap_val_ff;
    logic nxt_strap_val;

    // sequencer state is read here, so it is declared first
    typedef enum logic [2:0] {LD_SYNC, LD_SETTLE, LD_STRAP, LD_DEFAULT, LD_IDLE} load_state_t;

    load_state_t load_state_ff;
    load_state_t nxt_load_state;

    strap_sync u_strap_sync (
        .core_clk  (core_clk),
        .rst       (rst),
        .pin_in    (pause_advert_strap),
        .level_out (strap_sync_level)
    );

    // taken once on the third edge after release; later pin motion ignored
    always_comb begin
        nxt_strap_taken = strap_taken_ff;
        nxt_strap_val   = strap_val_ff;
        if (!strap_taken_ff && load_state_ff == LD_STRAP) begin
            nxt_strap_taken = 1'b1;
            nxt_strap_val   = strap_sync_level;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            strap_taken_ff <= 1'b0;
            strap_val_ff   <= 1'b0;
        end else begin
            strap_taken_ff <= nxt_strap_taken;
            strap_val_ff   <= nxt_strap_val;
        end
    end

    // ************************************************************
    // loader sequencing
    // ************************************************************
    logic        busy_ff;
    logic        nxt_busy;

    // synchroniser resets to zero, so the pin is only valid two edges after release
    always_comb begin
        nxt_load_state = load_state_ff;
        unique case (load_state_ff)
            LD_SYNC:    nxt_load_state = LD_SETTLE;
            LD_SETTLE:  nxt_load_state = LD_STRAP;
            LD_STRAP:   nxt_load_state = LD_DEFAULT;
            LD_DEFAULT: nxt_load_state = LD_IDLE;
            LD_IDLE: begin
                if (reload_cmd) begin
                    nxt_load_state = LD_DEFAULT;
                end
            end
            default:    nxt_load_state = LD_SYNC;
        endcase
        nxt_busy = (nxt_load_state != LD_IDLE);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            load_state_ff <= LD_SYNC;
            busy_ff       <= 1'b1;
        end else begin
            load_state_ff <= nxt_load_state;
            busy_ff       <= nxt_busy;
        end
    end

    // ************************************************************
    // advertisement register
    // ************************************************************
    adv_fields_t adv_ff;
    adv_fields_t nxt_adv;
    adv_fields_t dflt;
    logic        sw_wr;
    logic [15:0] sw_data;

    function automatic adv_fields_t unpack16(input logic [15:0] d);
        adv_fields_t f;
        f.asym_pause = d[BIT_ASYM_PAUSE];
        f.sym_pause  = d[BIT_SYM_PAUSE];
        f.x_full     = d[BIT_X_FULL];
        f.x_half     = d[BIT_X_HALF];
        f.t_full     = d[BIT_T_FULL];
        f.t_half     = d[BIT_T_HALF];
        f.selector   = d[4:0];
        return f;
    endfunction : unpack16

    // only the writable fields exist, so other bits of a write fall away
    always_comb begin
        dflt.asym_pause = ~strap_val_ff;
        dflt.sym_pause  = ~strap_val_ff;
        dflt.x_full     = 1'b1;
        dflt.x_half     = 1'b1;
        dflt.t_full     = 1'b1;
        dflt.t_half     = 1'b1;
        dflt.selector   = SELECTOR_8023;

        sw_wr   = 1'b0;
        sw_data = ZERO16;
        if (reg_req.wr && reg_req.addr == ADV_OFFSET) begin
            sw_wr   = 1'b1;
            sw_data = reg_req.wdata[15:0];
        end else if (mii_req.wr && mii_req.index == MII_ADV_INDEX) begin
            sw_wr   = 1'b1;
            sw_data = mii_req.wdata;
        end

        nxt_adv = adv_ff;
        // loader data wins over the defaults, else its write would be lost
        if (busy_ff && loader_wr) begin
            nxt_adv = unpack16(loader_data);
        end else if (load_state_ff == LD_DEFAULT) begin
            nxt_adv = dflt;
        end else if (!busy_ff && sw_wr) begin
            nxt_adv = unpack16(sw_data);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            adv_ff <= '{asym_pause: 1'b0, sym_pause: 1'b0, x_full: 1'b1, x_half: 1'b1,
                        t_full: 1'b1, t_half: 1'b1, selector: SELECTOR_8023};
        end else begin
            adv_ff <= nxt_adv;
        end
    end

    // ************************************************************
    // read assembly
    // ************************************************************
    logic [15:0] adv_view;
    logic [15:0] partner_view;

    always_comb begin
        adv_view                 = ZERO16;
        adv_view[BIT_NEXT_PAGE]  = 1'b0;
        adv_view[BIT_REMOTE_FLT] = 1'b0;
        adv_view[BIT_T4]         = 1'b0;
        adv_view[BIT_ASYM_PAUSE] = adv_ff.asym_pause;
        adv_view[BIT_SYM_PAUSE]  = adv_ff.sym_pause;
        adv_view[BIT_X_FULL]     = adv_ff.x_full;
        adv_view[BIT_X_HALF]     = adv_ff.x_half;
        adv_view[BIT_T_FULL]     = adv_ff.t_full;
        adv_view[BIT_T_HALF]     = adv_ff.t_half;
        adv_view[4:0]            = adv_ff.selector;

        // emulated partner mirrors our abilities; never received from a wire
        partner_view                = adv_view;
        partner_view[BIT_NEXT_PAGE] = 1'b0;
        partner_view[BIT_ACK]       = 1'b1;
    end

    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic [15:0] mdata_ff;
    logic [15:0] nxt_mdata;
    logic        mvalid_ff;
    logic        nxt_mvalid;
    logic [15:0] advout_ff;

    // unmapped offsets read zero
    always_comb begin
        nxt_rvalid = reg_req.rd;
        nxt_rdata  = '0;
        if (reg_req.rd && reg_req.addr == ADV_OFFSET) begin
            nxt_rdata = {ZERO16, adv_view};
        end else if (reg_req.rd && reg_req.addr == PARTNER_OFFSET) begin
            nxt_rdata = {ZERO16, partner_view};
        end

        nxt_mvalid = mii_req.rd;
        nxt_mdata  = ZERO16;
        if (mii_req.rd && mii_req.index == MII_ADV_INDEX) begin
            nxt_mdata = adv_view;
        end else if (mii_req.rd && mii_req.index == MII_PARTNER_IDX) begin
            nxt_mdata = partner_view;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_ff  <= '0;
            rvalid_ff <= 1'b0;
            mdata_ff  <= ZERO16;
            mvalid_ff <= 1'b0;
            advout_ff <= ZERO16;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            mdata_ff  <= nxt_mdata;
            mvalid_ff <= nxt_mvalid;
            advout_ff <= adv_view;
        end
    end

    assign reg_rdata   = rdata_ff;
    assign reg_rvalid  = rvalid_ff;
    assign mii_rdata   = mdata_ff;
    assign mii_rvalid  = mvalid_ff;
    assign loader_busy = busy_ff;
    assign adv_word    = advout_ff;

endmodule : virtual_phy_autoneg_advertise

// ### src/vphy_adv_pkg.sv
// package: offsets, field layout and request types of the advertisement registers
package vphy_adv_pkg;

    localparam logic [8:0]  ADV_OFFSET      = 9'h1D0;
    localparam logic [8:0]  PARTNER_OFFSET  = 9'h1D4;
    localparam logic [8:0]  ADDR_MASK_LOW   = 9'h003;
    localparam logic [4:0]  MII_ADV_INDEX   = 5'h04;
    localparam logic [4:0]  MII_PARTNER_IDX = 5'h05;

    localparam int          BIT_NEXT_PAGE   = 15;
    localparam int          BIT_ACK         = 14;
    localparam int          BIT_REMOTE_FLT  = 13;
    localparam int          BIT_ASYM_PAUSE  = 11;
    localparam int          BIT_SYM_PAUSE   = 10;
    localparam int          BIT_T4          = 9;
    localparam int          BIT_X_FULL      = 8;
    localparam int          BIT_X_HALF      = 7;
    localparam int          BIT_T_FULL      = 6;
    localparam int          BIT_T_HALF      = 5;

    localparam logic [4:0]  SELECTOR_8023   = 5'h01;
    localparam logic [15:0] ZERO16          = 16'h0000;

    // writable advertisement fields
    typedef struct packed {
        logic       asym_pause;
        logic       sym_pause;
        logic       x_full;
        logic       x_half;
        logic       t_full;
        logic       t_half;
        logic [4:0] selector;
    } adv_fields_t;

    // register access request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [8:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;

    // serial management access, 16-bit view
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  index;
        logic [15:0] wdata;
    } mii_req_t;

endpackage : vphy_adv_pkg

// ### src/strap_sync.sv
// two-stage synchroniser for an asynchronous strap pin
`timescale 1ns/1ps
module strap_sync (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // pin and synchronised level
    input  wire logic pin_in,
    output logic      level_out
);
    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

    assign level_out = sync_ff;

endmodule : strap_sync

// ### testbench/vphy_adv_chk.sv
// checker: timing and fixed-bit properties on the advertisement block ports
`timescale 1ns/1ps
module vphy_adv_chk (
    // clock and reset
    input wire logic                   core_clk,
    input wire logic                   rst,
    // watched ports
    input wire vphy_adv_pkg::reg_req_t reg_req,
    input wire logic [31:0]            reg_rdata,
    input wire logic                   reg_rvalid,
    input wire vphy_adv_pkg::mii_req_t mii_req,
    input wire logic [15:0]            mii_rdata,
    input wire logic                   mii_rvalid,
    input wire logic                   loader_wr,
    input wire logic                   reload_cmd,
    input wire logic                   loader_busy,
    input wire logic [15:0]            adv_word
);
    import vphy_adv_pkg::*;
    // ****
    // properties
    // ****
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_PAD: assert property (reg_rvalid |-> reg_rdata[31:16] == ZERO16)
        else $error("padding bits not zero");
    AST_NEXT_PAGE: assert property (adv_word[BIT_NEXT_PAGE] == 1'h0)
        else $error("next page advertised");
    AST_REMOTE_FAULT: assert property (adv_word[BIT_REMOTE_FLT] == 1'h0)
        else $error("remote fault advertised");
    AST_T4: assert property (adv_word[BIT_T4] == 1'h0)
        else $error("t4 ability advertised");
    AST_RESERVED: assert property ((adv_word & 16'h5000) == ZERO16)
        else $error("reserved bit set");
    AST_PARTNER: assert property (reg_req.rd && reg_req.addr == PARTNER_OFFSET |=>
        reg_rvalid && reg_rdata[15:14] == 2'h1) else $error("partner page or ack wrong");
    AST_MII: assert property (mii_req.rd && mii_req.index == MII_ADV_INDEX |=>
        mii_rvalid && (mii_rdata & 16'hF200) == ZERO16) else $error("serial read wrong");
    // defaults land unless the loader wrote in the last busy cycle; adv_word lags one cycle
    AST_DEFAULT: assert property ($fell(loader_busy) && !$past(loader_wr) |=> adv_word[8:0] == 9'h1E1)
        else $error("defaults not restored");
    AST_WRITE: assert property (reg_req.wr && reg_req.addr == ADV_OFFSET && !loader_busy && !loader_wr
        && !reload_cmd |-> ##2 (adv_word & 16'h0DFF) == ($past(reg_req.wdata[15:0], 2) & 16'h0DFF))
        else $error("write not applied");
endmodule : vphy_adv_chk

bind virtual_phy_autoneg_advertise vphy_adv_chk u_chk (
    .core_clk(core_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .mii_req(mii_req), .mii_rdata(mii_rdata), .mii_rvalid(mii_rvalid), .loader_wr(loader_wr),
    .reload_cmd(reload_cmd), .loader_busy(loader_busy), .adv_word(adv_word)
);

// ### testbench/test_virtual_phy_autoneg_advertise.sv
// self-checking bench for the advertisement register block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module test_virtual_phy_autoneg_advertise;
    import vphy_adv_pkg::*;
    logic        core_clk = 1'h0;
    logic        rst = 1'h1;
    logic        pause_advert_strap = 1'h0;
    reg_req_t    reg_req = '0;
    mii_req_t    mii_req = '0;
    logic        reload_cmd = 1'h0;
    logic        loader_wr = 1'h0;
    logic [15:0] loader_data = 16'h0000;
    logic [31:0] reg_rdata, got, w, shadow;
    logic [15:0] mii_rdata, adv_word;
    logic        reg_rvalid, mii_rvalid, loader_busy;
    int          n_mismatch = 0;
    int          checks_done = 0;
    always #25 core_clk = ~core_clk;
    virtual_phy_autoneg_advertise u_dut (
        .core_clk(core_clk), .rst(rst), .pause_advert_strap(pause_advert_strap), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .mii_req(mii_req), .mii_rdata(mii_rdata),
        .mii_rvalid(mii_rvalid), .loader_wr(loader_wr), .loader_data(loader_data), .reload_cmd(reload_cmd),
        .loader_busy(loader_busy), .adv_word(adv_word)
    );
    // ****
    // helpers
    // ****
    function automatic logic [31:0] dflt(input logic s);
        return {20'h00000, {2{~s}}, 10'h1E1};
    endfunction : dflt
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task automatic wait_idle();
        int i;
        for (i = 0; i < 40 && loader_busy !== 1'h0; i++) @(negedge core_clk);
        if (loader_busy !== 1'h0) begin
            n_mismatch++;
            wrap_up();
        end
    endtask : wait_idle
    // m selects the serial path; a[2] picks the partner index there
    task automatic acc(input bit m, input bit wr, input logic [8:0] a, input logic [31:0] wd,
                       output logic [31:0] d);
        @(negedge core_clk);
        if (m)
            mii_req = '{rd: !wr, wr: wr, index: a[2] ? MII_PARTNER_IDX : MII_ADV_INDEX, wdata: wd[15:0]};
        else
            reg_req = '{rd: !wr, wr: wr, addr: a, wdata: wd};
        @(negedge core_clk);
        reg_req = '0;
        mii_req = '0;
        d = m ? {16'h0000, mii_rdata} : reg_rdata;
        if (!wr) `CHK("rvalid", 1'h1, m ? mii_rvalid : reg_rvalid)
    endtask : acc
    task automatic do_reset(input logic s);
        rst = 1'h1;
        pause_advert_strap = s;
        repeat (20) @(negedge core_clk);
        rst = 1'h0;
        wait_idle();
    endtask : do_reset
    // ****
    // scenarios
    // ****
    initial begin
        int k;
        void'($urandom(38769));
        for (k = 0; k < 2; k++) begin
            do_reset(k[0]);
            acc(0, 0, ADV_OFFSET, 0, got);
            `CHK("adv reset", dflt(k[0]), got)
            acc(1, 0, ADV_OFFSET, 0, got);
            `CHK("mii reset", dflt(k[0]), got)
        end
        pause_advert_strap = 1'h0;
        acc(0, 1, ADV_OFFSET, 32'hFFFFFFE1, got);
        acc(0, 0, ADV_OFFSET, 0, got);
        `CHK("all ones", 32'h00000DE1, got)
        @(negedge core_clk);
        reload_cmd = 1'h1;
        @(negedge core_clk);
        reload_cmd = 1'h0;
        repeat (2) @(negedge core_clk);
        wait_idle();
        acc(0, 0, ADV_OFFSET, 0, got);
        `CHK("reload", dflt(1'h1), got)
        @(negedge core_clk);
        reload_cmd = 1'h1;
        @(negedge core_clk);
        reload_cmd  = 1'h0;
        loader_wr   = 1'h1;
        loader_data = 16'hB6A1;
        @(negedge core_clk);
        loader_wr = 1'h0;
        wait_idle();
        acc(0, 0, ADV_OFFSET, 0, got);
        `CHK("loader", 32'h000004A1, got)
        for (k = 0; k < 24; k++) begin
            w = ($urandom() & 32'hFFFFFFE0) | 32'h00000001;
            shadow = w & 32'h00000DFF;
            acc(k[0], 1, ADV_OFFSET, w, got);
            acc(!k[0], 0, ADV_OFFSET, 0, got);
            `CHK("rw", shadow, got)
        end
        `CHK("adv word", shadow[15:0], adv_word)
        acc(0, 1, PARTNER_OFFSET, ~shadow, got);
        acc(0, 0, ADV_OFFSET, 0, got);
        `CHK("partner write", shadow, got)
        acc(0, 0, PARTNER_OFFSET, 0, got);
        `CHK("partner", 32'h00004000, got & 32'hFFFFC000)
        acc(1, 0, PARTNER_OFFSET, 0, got);
        `CHK("mii partner", 32'h00004000, got & 32'hFFFFC000)
        acc(0, 0, 9'h1D8, 0, got);
        `CHK("unmapped", 32'h00000000, got)
        wrap_up();
    end
endmodule : test_virtual_phy_autoneg_advertise
